// ---- hdl/mio_pkg.sv ----
package mio_pkg;

  // Width of one serial frame in bits.
  localparam int FRAME_BITS = 16;

  // Control register addresses carried in frame bits [14:11].
  localparam logic [3:0] ADDR_READBACK  = 4'h1;
  localparam logic [3:0] ADDR_ADC_SEQ   = 4'h2;
  localparam logic [3:0] ADDR_GP_CTRL   = 4'h3;
  localparam logic [3:0] ADDR_GPIO_DATA = 4'h9;
  localparam logic [3:0] ADDR_PWR_REF   = 4'hB;
  localparam logic [3:0] ADDR_SW_RESET  = 4'hF;

  // Pin configuration addresses, index 0 to 6: adc, dac, pull-down, gpo, gpi, od, tri.
  localparam logic [6:0][3:0] CFG_ADDR = {4'hD, 4'hC, 4'hA, 4'h8, 4'h6, 4'h5, 4'h4};
  // Each index names the register it may coexist with; itself when none.
  localparam logic [6:0][2:0] CFG_PARTNER = {3'h6, 3'h5, 3'h3, 3'h4, 3'h2, 3'h0, 3'h1};
  localparam int CFG_ADC = 0;
  localparam int CFG_DAC = 1;
  localparam int CFG_PD  = 2;
  localparam int CFG_GPO = 3;
  localparam int CFG_GPI = 4;
  localparam int CFG_OD  = 5;
  localparam int CFG_TRI = 6;

  // Field positions and keys.
  localparam logic [10:0] SW_RESET_KEY = 11'h5AC;
  localparam int PWR_REF_BIT  = 9;
  localparam int SEQ_TEMP_BIT = 8;
  localparam int SEQ_REP_BIT  = 9;
  localparam int GP_LOCK_BIT  = 7;
  localparam int GP_BUF_BIT   = 8;
  localparam int RB_EN_BIT    = 6;
  localparam int RB_SEL_LSB   = 2;
  localparam logic [1:0] SIMULTANEOUS_UPDATE_MODE_DIRECT = 2'h0;
  localparam logic [1:0] SIMULTANEOUS_UPDATE_MODE_PULSE  = 2'h2;
  localparam logic [3:0] TEMP_ADDR   = 4'h8;

  // Values after reset.
  localparam logic [7:0] PD_RESET = 8'hFF;

  // Times in ns and the cycle counts derived from them.
  localparam int CLK_NS        = 10;
  localparam int RESET_TIME_NS = 250000;
  localparam int ADC_CONV_NS   = 2000;
  localparam int TEMP_BUF_NS   = 5000;
  localparam int TEMP_UNBUF_NS = 20000;
  localparam int RESET_CYCLES  = RESET_TIME_NS / CLK_NS;
  localparam int ADC_CONV_CYC  = (ADC_CONV_NS + CLK_NS - 1) / CLK_NS;
  localparam int TEMP_BUF_CYC  = (TEMP_BUF_NS + CLK_NS - 1) / CLK_NS;
  localparam int TEMP_UNBUF_CYC = (TEMP_UNBUF_NS + CLK_NS - 1) / CLK_NS;

  // Converter sequencer states.
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_CONV = 1'b1
  } mio_conv_t;

endpackage

// ---- hdl/mio_sync.sv ----
`timescale 1ns/100ps
`default_nettype none

// Two-flop level synchroniser; only the second stage is visible.
module mio_sync #(
  parameter int         W       = 1,
  parameter logic [7:0] RST_VAL = 8'h00
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;  // First stage, read by the second stage only.

  // Both stages reset to the idle level of the signal.
  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= RST_VAL[W-1:0];
      q    <= RST_VAL[W-1:0];
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

`default_nettype wire

// ---- hdl/mio_link.sv ----
`timescale 1ns/100ps
`default_nettype none

// Serial clock side of the port: frame shifter and readback shifter.
module mio_link
  import mio_pkg::*;
(
  input  wire logic        sclk,
  input  wire logic        frame_sel_n,
  input  wire logic        serial_data_in,
  input  wire logic [15:0] tx_word,
  output logic      [15:0] rx_word,
  output logic             rx_done,
  output logic             serial_data_out
);

  logic [4:0] rx_cnt;  // Falling edges seen in this frame, saturates at 16.
  logic [3:0] tx_cnt;  // Rising edges seen in this frame.

  // The counters are cleared by the frame select itself, since the
  // serial clock may stand still between frames.
  // sample on falling edges
  always_ff @(negedge sclk or posedge frame_sel_n) begin
    if (frame_sel_n) begin
      rx_cnt  <= 5'h00;
      rx_done <= 1'b0;
    end else if (rx_cnt != 5'(FRAME_BITS)) begin
      rx_cnt  <= rx_cnt + 5'h01;
      rx_done <= (rx_cnt == 5'(FRAME_BITS - 1));
    end
  end

  // Extra clocks beyond sixteen are ignored so the word stays intact.
  // shift in MSB first
  always_ff @(negedge sclk) begin
    if (!frame_sel_n && rx_cnt != 5'(FRAME_BITS)) begin
      rx_word <= {rx_word[14:0], serial_data_in};
    end
  end

  // Bits go out on rising edges so the host can take them on falling edges.
  // The word is static between frames, so no crossing is needed for it.
  // shift readback out
  always_ff @(posedge sclk or posedge frame_sel_n) begin
    if (frame_sel_n) begin
      tx_cnt          <= 4'h0;
      serial_data_out <= 1'b0;
    end else begin
      tx_cnt          <= tx_cnt + 4'h1;
      serial_data_out <= tx_word[4'hF - tx_cnt];
    end
  end

endmodule

`default_nettype wire

// ---- hdl/mio_cmd_port.sv ----
// Notes on behaviour
// - Reference off after reset, on via bit 9.
// - Reset pin fall restores all defaults.
// - Reset takes 250 us; no writes meanwhile.
// - Writing 0x5AC to soft reset resets all.
// - Sequence bit 8 adds temperature conversion.
// - Temperature result carries channel address 0b1000.
// - Temperature conversion 5 us buffered, 20 us otherwise.
// - Sixteen-bit frame; bit 15 picks write kind.
// - Control write: address 14:11, data 10:0.
// - Converter write: channel 14:12, code 11:0.
// - Power-up loads defaults for 250 us.
// - Frame starts on select low; falling-edge sampling.
// - Command executes when select returns high.
// - Readback register shifts out next frame.
// - During conversions only results are read back.
// - Config bit one assigns function to pin.
// - Latest configuration write wins, except pairs.
// - Converter output plus input: output drives.
// - Digital in plus out: drives, input readable.
// - Lock bit blocks pin configuration writes.
// - Configuration addresses select functions; bits map pins.
// - Lock is bit 7 of control register.
// - Converter writes honour the update mode.
`timescale 1ns/100ps
`default_nettype none

module mio_cmd_port
  import mio_pkg::*;
#(
  parameter int RESET_CYC = RESET_CYCLES
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic         reset_pin_n,
  input  wire logic         sclk,
  input  wire logic         frame_sel_n,
  input  wire logic         serial_data_in,
  output logic              serial_data_out,
  input  wire logic [7:0]   io_pin_in,
  output logic      [7:0]   io_pin_out,
  output logic      [7:0]   io_pin_oe,
  output logic      [7:0]   pin_adc_sel,
  output logic      [7:0]   pin_dac_en,
  output logic      [7:0]   pin_pulldown,
  output logic      [7:0]   pin_tristate,
  output logic              ref_enable,
  output logic              config_busy,
  output logic              conv_start,
  output logic      [3:0]   conv_channel,
  output logic              conv_busy,
  input  wire logic [11:0]  adc_result,
  output logic      [95:0]  dac_code
);

  localparam int BW = $clog2(RESET_CYC + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Crossing from the pins and the serial clock domain.

  logic        cs_s, done_s, rpin_s;   // Synchronised levels.
  logic        cs_prev, done_prev, rpin_prev;
  logic [7:0]  io_in_s;                // Synchronised pin levels.
  logic [15:0] rx_word;                // Frame word, stable after rx_done.
  logic        rx_done;
  logic [15:0] tx_word;                // Word offered on the next frame.

  mio_link u_link (
    .sclk            (sclk),
    .frame_sel_n     (frame_sel_n),
    .serial_data_in  (serial_data_in),
    .tx_word         (tx_word),
    .rx_word         (rx_word),
    .rx_done         (rx_done),
    .serial_data_out (serial_data_out)
  );

  mio_sync #(.W(3), .RST_VAL(8'h05)) u_sync_ctl (
    .clk (clk_sys),
    .rst (rst),
    .d   ({reset_pin_n, rx_done, frame_sel_n}),
    .q   ({rpin_s, done_s, cs_s})
  );

  mio_sync #(.W(8), .RST_VAL(8'h00)) u_sync_io (
    .clk (clk_sys),
    .rst (rst),
    .d   (io_pin_in),
    .q   (io_in_s)
  );

  // One more stage for edge detection, behind the synchronisers.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cs_prev   <= 1'b1;
      done_prev <= 1'b0;
      rpin_prev <= 1'b1;
    end else begin
      cs_prev   <= cs_s;
      done_prev <= done_s;
      rpin_prev <= rpin_s;
    end
  end

  wire cs_rise   = cs_s & ~cs_prev;
  wire cs_fall   = ~cs_s & cs_prev;
  wire done_rise = done_s & ~done_prev;
  wire pin_fall  = ~rpin_s & rpin_prev;

  ////////////////////////////////////////////////////////////////////////////
  // Frame capture and decode.

  logic [15:0] cmd_word;    // Copy of a complete frame.
  logic        frame_pend;  // Sixteen bits arrived, select not yet high.

  // A short frame never sets the pending flag and is dropped.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      frame_pend <= 1'b0;
      cmd_word   <= 16'h0000;
    end else begin
      frame_pend <= ~cs_rise & (frame_pend | done_rise);
      if (done_rise) begin
        cmd_word <= rx_word;
      end
    end
  end

  wire        exec      = cs_rise & (frame_pend | done_rise);
  wire [15:0] exec_word = done_rise ? rx_word : cmd_word;
  wire        exec_ok   = exec & ~config_busy;
  wire        ctl_wr    = exec_ok & ~exec_word[15];
  wire        dac_wr    = exec_ok & exec_word[15];
  wire [3:0]  addr      = exec_word[14:11];
  wire [10:0] wdata     = exec_word[10:0];

  wire sw_hit = ctl_wr & (addr == ADDR_SW_RESET) & (wdata == SW_RESET_KEY);
  wire clear  = rst | pin_fall | sw_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Reset and power-up interval.

  logic [BW-1:0] busy_cnt;  // Cycles left of default loading.

  always_ff @(posedge clk_sys) begin
    if (clear) begin
      busy_cnt    <= BW'(RESET_CYC);
      config_busy <= 1'b1;
    end else begin
      busy_cnt    <= (busy_cnt != '0) ? busy_cnt - BW'(1) : busy_cnt;
      config_busy <= (busy_cnt > BW'(1));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers.

  logic [9:0] seq;        // Channels [7:0], temperature, repeat.
  logic [8:0] gp_ctrl;    // Lock and buffer enable among others.
  logic [7:0] gpio_data;  // Levels for digital outputs.
  logic [1:0] simultaneous_update_mode_mode;  // Input-to-output transfer mode.
  logic       rb_armed;   // A readback word waits in tx_word.

  wire rb_wr     = ctl_wr & (addr == ADDR_READBACK);
  wire simultaneous_update_mode_once = rb_wr & (wdata[1:0] == SIMULTANEOUS_UPDATE_MODE_PULSE);
  wire seq_wr    = ctl_wr & (addr == ADDR_ADC_SEQ);
  wire seq_on    = |seq[8:0];

  // A transfer request leaves the stored mode as it was.
  always_ff @(posedge clk_sys) begin
    if (clear) begin
      seq        <= 10'h000;
      gp_ctrl    <= 9'h000;
      gpio_data  <= 8'h00;
      simultaneous_update_mode_mode  <= SIMULTANEOUS_UPDATE_MODE_DIRECT;
      ref_enable <= 1'b0;
    end else begin
      if (seq_wr) begin
        seq <= wdata[9:0];
      end
      if (ctl_wr && addr == ADDR_GP_CTRL) begin
        gp_ctrl <= wdata[8:0];
      end
      if (ctl_wr && addr == ADDR_GPIO_DATA) begin
        gpio_data <= wdata[7:0];
      end
      if (rb_wr && !simultaneous_update_mode_once) begin
        simultaneous_update_mode_mode <= wdata[1:0];
      end
      if (ctl_wr && addr == ADDR_PWR_REF) begin
        ref_enable <= wdata[PWR_REF_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin configuration registers.

  logic [7:0] cfg [7];
  logic [6:0] cfg_hit;

  wire cfg_wr = ctl_wr & (|cfg_hit) & ~gp_ctrl[GP_LOCK_BIT];

  // A write sets its own pins and takes them from every register except
  // its partner, so the last write decides a pin's function.
  for (genvar j = 0; j < 7; j++) begin : g_cfg
    assign cfg_hit[j] = (addr == CFG_ADDR[j]);
    always_ff @(posedge clk_sys) begin
      if (clear) begin
        cfg[j] <= (j == CFG_PD) ? PD_RESET : 8'h00;
      end else if (cfg_wr && cfg_hit[j]) begin
        cfg[j] <= wdata[7:0];
      end else if (cfg_wr && !cfg_hit[CFG_PARTNER[j]]) begin
        cfg[j] <= cfg[j] & ~wdata[7:0];
      end
    end
  end

  assign pin_adc_sel  = cfg[CFG_ADC];
  assign pin_dac_en   = cfg[CFG_DAC];
  assign pin_pulldown = cfg[CFG_PD];
  assign pin_tristate = cfg[CFG_TRI];

  // Digital drive; a converter output or three-state wins over it.
  // converter output drives
  always_ff @(posedge clk_sys) begin
    if (clear) begin
      io_pin_out <= 8'h00;
      io_pin_oe  <= 8'h00;
    end else begin
      io_pin_out <= gpio_data & ~cfg[CFG_OD];
      io_pin_oe  <= cfg[CFG_GPO] & ~cfg[CFG_TRI] & ~cfg[CFG_DAC]
                    & (~cfg[CFG_OD] | ~gpio_data);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Converter input and output registers.

  logic [11:0] dac_in  [8];
  logic [11:0] dac_out [8];

  for (genvar c = 0; c < 8; c++) begin : g_dac
    wire hit = dac_wr & (exec_word[14:12] == 3'(c));
    always_ff @(posedge clk_sys) begin
      if (clear) begin
        dac_in[c]  <= 12'h000;
        dac_out[c] <= 12'h000;
      end else begin
        if (hit) begin
          dac_in[c] <= exec_word[11:0];
        end
        if (hit && simultaneous_update_mode_mode == SIMULTANEOUS_UPDATE_MODE_DIRECT) begin
          dac_out[c] <= exec_word[11:0];
        end else if (simultaneous_update_mode_once) begin
          dac_out[c] <= dac_in[c];
        end
      end
    end
    assign dac_code[c*12 +: 12] = dac_out[c];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer.

  mio_conv_t   state;
  logic [8:0]  pending;   // Entries still to convert in this pass.
  logic [11:0] conv_cnt;  // Cycles left in the running conversion.
  logic [3:0]  enc [10];  // Running encode of the lowest pending entry.

  // Lowest pending entry as one-hot, then as its index; 8 is temperature.
  wire [8:0] pick = pending & (~pending + 9'h001);
  assign enc[0] = 4'h0;
  for (genvar i = 0; i < 9; i++) begin : g_enc
    assign enc[i+1] = enc[i] | (pick[i] ? 4'(i) : 4'h0);
  end
  wire [3:0] pick_idx = enc[9];
  wire [8:0] rest     = pending & ~pick;

  wire [11:0] dur = (pick_idx != TEMP_ADDR) ? 12'(ADC_CONV_CYC)
                  : gp_ctrl[GP_BUF_BIT] ? 12'(TEMP_BUF_CYC) : 12'(TEMP_UNBUF_CYC);
  wire start    = cs_fall & (state == ST_IDLE) & (|pending) & ~config_busy;
  wire conv_end = (state == ST_CONV) & (conv_cnt == 12'h001);

  // A new frame starts the next conversion; one must end first.
  // temperature joins sequence
  always_ff @(posedge clk_sys) begin
    if (clear) begin
      state        <= ST_IDLE;
      pending      <= 9'h000;
      conv_cnt     <= 12'h000;
      conv_start   <= 1'b0;
      conv_busy    <= 1'b0;
      conv_channel <= 4'h0;
    end else begin
      conv_start <= start;
      if (seq_wr) begin
        pending <= wdata[8:0];
      end else if (start) begin
        pending <= (rest == 9'h000 && seq[SEQ_REP_BIT]) ? seq[8:0] : rest;
      end
      unique case (state)
        ST_IDLE: begin
          if (start) begin
            state        <= ST_CONV;
            conv_cnt     <= dur;
            conv_busy    <= 1'b1;
            conv_channel <= pick_idx;
          end
        end
        ST_CONV: begin
          conv_cnt <= conv_cnt - 12'h001;
          if (conv_end) begin
            state     <= ST_IDLE;
            conv_busy <= 1'b0;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Word for the next frame.

  logic [15:0] rb_val;  // Contents of the register picked for readback.

  // Pins set as input report their real level, driven or not.
  always_comb begin
    unique case (wdata[RB_SEL_LSB +: 4])
      ADDR_ADC_SEQ:   rb_val = {6'h00, seq};
      ADDR_GP_CTRL:   rb_val = {7'h00, gp_ctrl};
      ADDR_GPIO_DATA: rb_val = {8'h00, gpio_data};
      ADDR_PWR_REF:   rb_val = {6'h00, ref_enable, 9'h000};
      CFG_ADDR[0]:    rb_val = {8'h00, cfg[CFG_ADC]};
      CFG_ADDR[1]:    rb_val = {8'h00, cfg[CFG_DAC]};
      CFG_ADDR[2]:    rb_val = {8'h00, cfg[CFG_PD]};
      CFG_ADDR[3]:    rb_val = {8'h00, cfg[CFG_GPO]};
      CFG_ADDR[4]:    rb_val = {8'h00, io_in_s & cfg[CFG_GPI]};
      CFG_ADDR[5]:    rb_val = {8'h00, cfg[CFG_OD]};
      CFG_ADDR[6]:    rb_val = {8'h00, cfg[CFG_TRI]};
      default:        rb_val = 16'h0000;
    endcase
  end

  // Results take precedence; a readback word lives for one frame.
  always_ff @(posedge clk_sys) begin
    if (clear) begin
      tx_word  <= 16'h0000;
      rb_armed <= 1'b0;
    end else if (conv_end) begin
      tx_word  <= {conv_channel, adc_result};
      rb_armed <= 1'b0;
    end else if (rb_wr && wdata[RB_EN_BIT] && !seq_on) begin
      tx_word  <= rb_val;
      rb_armed <= 1'b1;
    end else if (exec_ok && rb_armed) begin
      tx_word  <= 16'h0000;
      rb_armed <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  logic [11:0] busy_len;  // Length of the current conversion so far.

  always_ff @(posedge clk_sys) begin
    if (rst || !conv_busy) begin
      busy_len <= 12'h000;
    end else begin
      busy_len <= busy_len + 12'h001;
    end
  end

  a_ref_reset_off: assert property (@(posedge clk_sys) disable iff (rst)
    pin_fall |=> !ref_enable ##1 !ref_enable)
    else $error("reference still on after reset");

  a_pin_reset_defaults: assert property (@(posedge clk_sys) disable iff (rst)
    pin_fall |=> (pin_pulldown == PD_RESET) && (io_pin_oe == 8'h00) && config_busy)
    else $error("pin reset left state");

  a_soft_reset_clear: assert property (@(posedge clk_sys) disable iff (rst)
    sw_hit |=> !ref_enable && (pin_dac_en == 8'h00) && !conv_busy)
    else $error("soft reset incomplete");

  a_busy_after_clear: assert property (@(posedge clk_sys) disable iff (rst)
    sw_hit |=> config_busy [*8])
    else $error("busy dropped too early");

  a_conv_length: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(conv_busy) |-> (conv_channel != TEMP_ADDR) || (busy_len ==
      (gp_ctrl[GP_BUF_BIT] ? 12'(TEMP_BUF_CYC) : 12'(TEMP_UNBUF_CYC))))
    else $error("temperature conversion length wrong");

  a_temp_tag: assert property (@(posedge clk_sys) disable iff (rst)
    conv_end && conv_channel == TEMP_ADDR |=> tx_word[15:12] == TEMP_ADDR)
    else $error("temperature result not tagged");

  a_lock_holds: assert property (@(posedge clk_sys) disable iff (rst)
    ctl_wr && (|cfg_hit) && gp_ctrl[GP_LOCK_BIT] && !clear |=>
      $stable(pin_adc_sel) && $stable(pin_dac_en) && $stable(pin_tristate))
    else $error("locked configuration changed");

  a_rb_blocked: assert property (@(posedge clk_sys) disable iff (rst)
    rb_wr && seq_on |=> !rb_armed)
    else $error("readback taken while sequencing");

  a_dac_direct: assert property (@(posedge clk_sys) disable iff (rst)
    dac_wr && exec_word[14:12] == 3'h0 && simultaneous_update_mode_mode == SIMULTANEOUS_UPDATE_MODE_DIRECT && !clear
      |=> dac_code[11:0] == $past(exec_word[11:0]))
    else $error("direct converter update missing");

  c_temp_conv: cover property (@(posedge clk_sys) conv_end && conv_channel == TEMP_ADDR);
  c_readback: cover property (@(posedge clk_sys) rb_armed && cs_fall);
  c_soft_reset: cover property (@(posedge clk_sys) sw_hit);
  c_dac_write: cover property (@(posedge clk_sys) dac_wr);

endmodule

`default_nettype wire

// ---- tb/mio_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none

// Host controller model; the serial clock idles low and runs only in frames.
module mio_host_model (
  output logic      sclk,
  output logic      frame_sel_n,
  output logic      serial_data_in,
  input  wire logic serial_data_out
);
  // Idle bus: no frame selected.
  initial begin
    sclk = 1'b0;
    frame_sel_n = 1'b1;
    serial_data_in = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // One sixteen-bit transfer at an 80 ns serial clock period.
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    int i;
    #3;
    frame_sel_n = 1'b0;
    #20;
    for (i = 15; i >= 0; i--) begin
      serial_data_in = w[i];
      #20 sclk = 1'b1;
      #40 r[i] = serial_data_out;
      sclk = 1'b0;
      #20;
    end
    frame_sel_n = 1'b1;
    // Released data line shows the inverse so a stale bit is never seen.
    serial_data_in = ~w[0];
    #400;
  endtask
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import mio_pkg::*;

  // Row of the table: frame sent and {ref, adc, dac, pd, tri} after it.
  typedef struct packed {
    logic [15:0] w;
    logic [32:0] e;
  } mio_row_t;

  logic        clk_sys;
  logic        rst;
  logic        reset_pin_n;
  logic [11:0] adc_result;
  wire         sclk;
  wire         frame_sel_n;
  wire         serial_data_in;
  wire         serial_data_out;
  logic [7:0]  io_pin_out;
  logic [7:0]  io_pin_oe;
  logic [7:0]  adc;
  logic [7:0]  dac;
  logic [7:0]  pd;
  logic [7:0]  tri_s;
  logic        ref_enable;
  logic        config_busy;
  logic        conv_start;
  logic [3:0]  conv_channel;
  logic        conv_busy;
  logic [95:0] dac_code;
  logic [15:0] rd;
  logic [32:0] st;
  int          fails;
  int          checks_done;
  int          n;
  mio_row_t    rows [6];

  // Pin state gathered for one compare.
  assign st = {ref_enable, adc, dac, pd, tri_s};

  // Pin levels seen by the device: driven pins show their output, others read 8'hA5.
  wire [7:0] pins = (io_pin_oe & io_pin_out) | (~io_pin_oe & 8'hA5);

  mio_cmd_port #(.RESET_CYC(50)) u_dut (
    .clk_sys(clk_sys), .rst(rst), .reset_pin_n(reset_pin_n), .sclk(sclk),
    .frame_sel_n(frame_sel_n), .serial_data_in(serial_data_in),
    .serial_data_out(serial_data_out), .io_pin_in(pins),
    .io_pin_out(io_pin_out), .io_pin_oe(io_pin_oe), .pin_adc_sel(adc),
    .pin_dac_en(dac), .pin_pulldown(pd), .pin_tristate(tri_s),
    .ref_enable(ref_enable), .config_busy(config_busy),
    .conv_start(conv_start), .conv_channel(conv_channel),
    .conv_busy(conv_busy), .adc_result(adc_result), .dac_code(dac_code));

  mio_host_model u_host (
    .sclk(sclk), .frame_sel_n(frame_sel_n),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out));

  // System clock, 10 ns period.
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////
  // Compare, verdict and bounded waits.
  task automatic chk(input string nm, input logic [63:0] s, input logic [63:0] e);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // A hang counts as a mismatch and ends the run.
  task automatic wait_busy(input logic lvl);
    int k;
    for (k = 0; k < 400 && config_busy !== lvl; k++) @(posedge clk_sys);
    if (config_busy !== lvl) begin
      fails++;
      close_out();
    end
  endtask

  task automatic frame(input logic [15:0] w);
    u_host.xfer(w, rd);
    repeat (10) @(posedge clk_sys);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence; bits 10:9 of control frames stay zero unless a field needs them.
  initial begin
    rst = 1'b1;
    reset_pin_n = 1'b1;
    adc_result = 12'h5A3;
    fails = 0;
    checks_done = 0;
    rows = '{'{16'h2003, {1'b0, 32'h0300FC00}}, '{16'h2803, {1'b0, 32'h0303FC00}},
             '{16'h6801, {1'b0, 32'h0202FC01}}, '{16'h5A00, {1'b1, 32'h0202FC01}},
             '{16'h1880, {1'b1, 32'h0202FC01}}, '{16'h20FF, {1'b1, 32'h0202FC01}}};
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    // Host waits out the configuration interval before any frame.
    wait_busy(1'b0);
    chk("defaults", st, {1'b0, 32'h0000FF00});
    // configure while idle; the last row probes the lock.
    foreach (rows[i]) begin
      frame(rows[i].w);
      chk("pins", st, rows[i].e);
    end
    frame(16'hDABC);
    chk("dac", dac_code[71:60], 12'hABC);
    frame(16'h8123);
    chk("dac0", dac_code[11:0], 12'h123);
    // Hold mode keeps the output, the transfer request then loads it.
    frame(16'h0801);
    frame(16'h8456);
    chk("dac hold", dac_code[11:0], 12'h123);
    frame(16'h0802);
    chk("dac load", dac_code[11:0], 12'h456);
    frame(16'h7DAB);
    chk("bad key", {config_busy, st}, {2'b01, 32'h0202FC01});
    // Temperature only in the sequence; buffer is off.
    frame(16'h1100);
    fork
      u_host.xfer(16'h0000, rd);
      begin
        for (n = 0; n < 300 && conv_start !== 1'b1; n++) @(posedge clk_sys);
        chk("temp start", conv_start, 1'b1);
        chk("temp ch", conv_channel, TEMP_ADDR);
        for (n = 0; n < 5 && conv_busy !== 1'b1; n++) @(posedge clk_sys);
        for (n = 0; n < 3000 && conv_busy === 1'b1; n++) @(posedge clk_sys);
        chk("temp len", n, TEMP_UNBUF_CYC);
      end
    join
    repeat (10) @(posedge clk_sys);
    u_host.xfer(16'h0000, rd);
    chk("temp word", rd, {TEMP_ADDR, 12'h5A3});
    // A readback request while a sequence is set is ignored.
    frame(16'h0868);
    u_host.xfer(16'h0000, rd);
    chk("rb blocked", rd, {TEMP_ADDR, 12'h5A3});
    // Soft reset, then the reset pin, each from a configured state.
    for (int k = 0; k < 2; k++) begin
      frame(16'h5A00);
      if (k == 0) u_host.xfer(16'h7DAC, rd);
      else begin
        reset_pin_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        reset_pin_n <= 1'b1;
      end
      wait_busy(1'b1);
      wait_busy(1'b0);
      chk("reset", st, {1'b0, 32'h0000FF00});
    end
    // pins set while idle and unlocked; pin 0 is driven low and reads low.
    frame(16'h4003);
    frame(16'h4802);
    frame(16'h5003);
    chk("drive", {io_pin_oe, io_pin_out}, 16'h0302);
    frame(16'h0868);
    u_host.xfer(16'h0000, rd);
    chk("gpi read", rd, 16'h0002);
    close_out();
  end
endmodule
`default_nettype wire
